/* File: hdl/inr_pkg.sv */
// Constants, register map and shared types of the inrush detector.
// Assumes a single clock domain and an AHB-Lite master holding whole-word transfers.
package inr_pkg;

	// Widths of measured magnitudes, the two settings, products, the event count and register offsets.
	localparam int MAG_W   = 16;
	localparam int RATIO_W = 6;
	localparam int MIN_W   = 7;
	localparam int PROD_W  = 24;
	localparam int CNT_W   = 16;
	localparam int ADDR_W  = 5;

	// Register byte offsets.
	localparam logic [ADDR_W-1:0] OFS_CTRL   = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_RATIO  = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_MINLVL = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_RATED  = 5'h0C;
	localparam logic [ADDR_W-1:0] OFS_FLAGS  = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_EVSTAT = 5'h14;
	localparam logic [ADDR_W-1:0] OFS_EVMASK = 5'h18;
	localparam logic [ADDR_W-1:0] OFS_EVCNT  = 5'h1C;

	// Field positions.
	localparam int CTRL_OP_BIT    = 0;
	localparam int FLAGS_ANY_BIT  = 3;
	localparam int FLAGS_BLK_BIT  = 4;
	localparam int FLAGS_OP_BIT   = 5;
	localparam int EV_ON_BIT      = 0;
	localparam int EV_OFF_BIT     = 1;
	localparam int EV_W           = 2;

	// Setting limits, reset values and the percent scale.
	localparam logic [RATIO_W-1:0] RATIO_LO  = 6'h05;
	localparam logic [RATIO_W-1:0] RATIO_HI  = 6'h32;
	localparam logic [RATIO_W-1:0] RATIO_RST = 6'h0F;
	localparam logic [MIN_W-1:0]   MINLVL_LO  = 7'h14;
	localparam logic [MIN_W-1:0]   MINLVL_HI  = 7'h64;
	localparam logic [MIN_W-1:0]   MINLVL_RST = 7'h1E;
	localparam logic [MAG_W-1:0]   RATED_RST  = 16'h1000;
	localparam logic [MIN_W-1:0]   PCT_SCALE  = 7'h64;

	// One-hot states of the bus slave.
	typedef enum logic [2:0] {
		INR_BUS_IDLE   = 3'b001,
		INR_BUS_ACCESS = 3'b010,
		INR_BUS_DONE   = 3'b100
	} inr_bus_e;

	// True when a*b is strictly greater than c*d, all unsigned.
	function automatic logic inr_prod_gt(input logic [MAG_W-1:0] a, input logic [MIN_W-1:0] b,
		input logic [MAG_W-1:0] c, input logic [MIN_W-1:0] d);
		logic [PROD_W-1:0] lhs;
		logic [PROD_W-1:0] rhs;
		lhs = PROD_W'(a) * PROD_W'(b);
		rhs = PROD_W'(c) * PROD_W'(d);
		return lhs > rhs;
	endfunction

endpackage

/* File: hdl/inr_phase_if.sv */
// Interface carrying one phase's measurements, settings and flag between top and comparator.
// Assumes the top drives every input each cycle.
`timescale 1ns/10ps
interface inr_phase_if;
	import inr_pkg::*;
	logic [MAG_W-1:0]   fund;
	logic [MAG_W-1:0]   harm;
	logic               strobe;
	logic               enable;
	logic [RATIO_W-1:0] ratio;
	logic [MIN_W-1:0]   min_level;
	logic [MAG_W-1:0]   rated;
	logic               flag_d;
	logic               flag;

	modport top (output fund, harm, strobe, enable, ratio, min_level, rated,
		input flag_d, flag);
	modport cmp (input fund, harm, strobe, enable, ratio, min_level, rated,
		output flag_d, flag);
endinterface

/* File: hdl/inr_phase_cmp.sv */
// Per-phase inrush decision: second harmonic against fundamental, gated by a floor level.
// Assumes magnitudes are steady while the sample strobe is high.
`timescale 1ns/10ps
module inr_phase_cmp
	import inr_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	inr_phase_if.cmp ph
);

	typedef struct packed {
		logic flag;
	} inr_cmp_s;

	inr_cmp_s st_q;
	inr_cmp_s st_d;
	logic     above_floor;
	logic     ratio_hit;

	// Compare without dividing: 100*harm > ratio*fund, 100*fund > min*rated.
	assign above_floor = inr_prod_gt(ph.fund, PCT_SCALE, ph.rated, ph.min_level);
	assign ratio_hit   = inr_prod_gt(ph.harm, PCT_SCALE, ph.fund, MIN_W'(ph.ratio));

	// Flag follows the strobe and is cleared at once when disabled.
	always_comb begin
		st_d = st_q;
		if (!ph.enable) begin
			st_d.flag = 1'b0;
		end else if (ph.strobe) begin
			st_d.flag = above_floor & ratio_hit;
		end
	end

	// State register.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign ph.flag_d = st_d.flag;
	assign ph.flag   = st_q.flag;

endmodule // inr_phase_cmp

/* File: hdl/inr_detector.sv */
// Top of the three-phase second-harmonic inrush detector with its AHB-Lite register slave.
// Assumes the Fourier stage drives magnitudes and a one-cycle sample strobe on hclk.
`timescale 1ns/10ps
module inr_detector
	import inr_pkg::*;
#(
	parameter int                 NPH       = 3,
	parameter logic [MAG_W-1:0]   RATED_DEF = RATED_RST
)(
	input  wire logic                      hclk,
	input  wire logic                      hresetn,
	// AHB-Lite slave.
	input  wire logic                      hsel,
	input  wire logic [31:0]               haddr,
	input  wire logic [1:0]                htrans,
	input  wire logic                      hwrite,
	input  wire logic [2:0]                hsize,
	input  wire logic [31:0]               hwdata,
	input  wire logic                      hready,
	output logic                           hreadyout,
	output logic                           hresp,
	output logic [31:0]                    hrdata,
	// Measurement stage.
	input  wire logic [NPH-1:0][MAG_W-1:0] phase_fund,
	input  wire logic [NPH-1:0][MAG_W-1:0] phase_harm,
	input  wire logic                      sample_strobe,
	// User logic block input.
	input  wire logic                      inrush_block_input,
	// Flags and events.
	output logic                           phase_a_inrush_flag,
	output logic                           phase_b_inrush_flag,
	output logic                           phase_c_inrush_flag,
	output logic                           any_phase_inrush_flag,
	output logic                           inrush_state_event,
	output logic                           inrush_state_value,
	output logic                           irq
);

	// Whole state of the top in one record.
	typedef struct packed {
		inr_bus_e           bus;
		logic [ADDR_W-1:0]  addr;
		logic               write;
		logic               op_on;
		logic [RATIO_W-1:0] ratio;
		logic [MIN_W-1:0]   minlvl;
		logic [MAG_W-1:0]   rated;
		logic [EV_W-1:0]    evstat;
		logic [EV_W-1:0]    evmask;
		logic [CNT_W-1:0]   evcnt;
		logic               any;
		logic               ev;
		logic               ev_val;
		logic [31:0]        rdata;
		logic               irq;
	} inr_top_s;

	inr_top_s st_q;
	inr_top_s st_d;

	inr_phase_if ph [NPH] ();

	logic             enable;
	logic [NPH-1:0]   flag_d;
	logic [NPH-1:0]   flag_q;
	logic             any_d;
	logic             addr_take;
	logic [EV_W-1:0]  ev_new;

	// Clamp a written ratio into its legal range.
	function automatic logic [RATIO_W-1:0] clamp_ratio(input logic [31:0] v);
		logic [RATIO_W-1:0] r;
		if (v < 32'(RATIO_LO)) begin
			r = RATIO_LO;
		end else if (v > 32'(RATIO_HI)) begin
			r = RATIO_HI;
		end else begin
			r = v[RATIO_W-1:0];
		end
		return r;
	endfunction

	// Clamp a written minimum level into its legal range.
	function automatic logic [MIN_W-1:0] clamp_min(input logic [31:0] v);
		logic [MIN_W-1:0] r;
		if (v < 32'(MINLVL_LO)) begin
			r = MINLVL_LO;
		end else if (v > 32'(MINLVL_HI)) begin
			r = MINLVL_HI;
		end else begin
			r = v[MIN_W-1:0];
		end
		return r;
	endfunction

	// Function is live only when switched on and not blocked.
	assign enable = st_q.op_on & ~inrush_block_input;

	// One comparator per phase, each with its own measurements.
	for (genvar i = 0; i < NPH; i++) begin : g_phase
		assign ph[i].fund      = phase_fund[i];
		assign ph[i].harm      = phase_harm[i];
		assign ph[i].strobe    = sample_strobe;
		assign ph[i].enable    = enable;
		assign ph[i].ratio     = st_q.ratio;
		assign ph[i].min_level = st_q.minlvl;
		assign ph[i].rated     = st_q.rated;
		assign flag_d[i]       = ph[i].flag_d;
		assign flag_q[i]       = ph[i].flag;

		inr_phase_cmp u_cmp (
			.hclk    (hclk),
			.hresetn (hresetn),
			.ph      (ph[i])
		);
	end

	// General flag uses next phase values so it moves in the same cycle as them.
	assign any_d = enable & (|flag_d);

	// A change of the general flag gives an on or an off event.
	assign ev_new[EV_ON_BIT]  = any_d & ~st_q.any;
	assign ev_new[EV_OFF_BIT] = ~any_d & st_q.any;

	// An address phase is taken only while no data phase is stalling.
	assign addr_take = hsel & htrans[1] & hready & (st_q.bus != INR_BUS_ACCESS);

	// Next state: bus slave, settings, detector outputs and events.
	always_comb begin
		st_d        = st_q;
		st_d.any    = any_d;
		st_d.ev     = |ev_new;
		st_d.ev_val = any_d;
		if (|ev_new) begin
			st_d.evcnt = st_q.evcnt + CNT_W'(1);
		end

		// Bus sequencing: one stall cycle, then a ready cycle.
		unique case (st_q.bus)
			INR_BUS_IDLE, INR_BUS_DONE: begin
				st_d.bus = INR_BUS_IDLE;
				if (addr_take) begin
					st_d.bus   = INR_BUS_ACCESS;
					st_d.addr  = haddr[ADDR_W-1:0];
					st_d.write = hwrite;
				end
			end
			INR_BUS_ACCESS: begin
				st_d.bus   = INR_BUS_DONE;
				st_d.rdata = 32'h0000_0000;
				if (st_q.write) begin
					unique case (st_q.addr)
						OFS_CTRL:   st_d.op_on  = hwdata[CTRL_OP_BIT];
						OFS_RATIO:  st_d.ratio  = clamp_ratio(hwdata);
						OFS_MINLVL: st_d.minlvl = clamp_min(hwdata);
						OFS_RATED:  st_d.rated  = hwdata[MAG_W-1:0];
						OFS_EVMASK: st_d.evmask = hwdata[EV_W-1:0];
						default: ;
					endcase
				end else begin
					unique case (st_q.addr)
						OFS_CTRL:   st_d.rdata[CTRL_OP_BIT] = st_q.op_on;
						OFS_RATIO:  st_d.rdata[RATIO_W-1:0] = st_q.ratio;
						OFS_MINLVL: st_d.rdata[MIN_W-1:0]   = st_q.minlvl;
						OFS_RATED:  st_d.rdata[MAG_W-1:0]   = st_q.rated;
						OFS_FLAGS: begin
							st_d.rdata[NPH-1:0]       = flag_q;
							st_d.rdata[FLAGS_ANY_BIT] = st_q.any;
							st_d.rdata[FLAGS_BLK_BIT] = inrush_block_input;
							st_d.rdata[FLAGS_OP_BIT]  = st_q.op_on;
						end
						OFS_EVSTAT: begin
							st_d.rdata[EV_W-1:0] = st_q.evstat;
							st_d.evstat          = '0;
						end
						OFS_EVMASK: st_d.rdata[EV_W-1:0]  = st_q.evmask;
						OFS_EVCNT:  st_d.rdata[CNT_W-1:0] = st_q.evcnt;
						default: ;
					endcase
				end
			end
			default: begin
				st_d.bus = INR_BUS_IDLE;
			end
		endcase

		// New events set after any read-clear, so a set in the clearing cycle wins.
		st_d.evstat = st_d.evstat | ev_new;
		st_d.irq    = |(st_d.evstat & st_d.evmask);
	end

	// State register with documented reset values.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q        <= '0;
			st_q.bus    <= INR_BUS_IDLE;
			st_q.ratio  <= RATIO_RST;
			st_q.minlvl <= MINLVL_RST;
			st_q.rated  <= RATED_DEF;
		end else begin
			st_q <= st_d;
		end
	end

	// Bus answers: stall during the access cycle, always OKAY.
	assign hreadyout = (st_q.bus != INR_BUS_ACCESS);
	assign hresp     = 1'b0;
	assign hrdata    = st_q.rdata;

	// Flag and event outputs, all from flip-flops.
	assign phase_a_inrush_flag   = flag_q[0];
	assign phase_b_inrush_flag   = flag_q[1];
	assign phase_c_inrush_flag   = flag_q[2];
	assign any_phase_inrush_flag = st_q.any;
	assign inrush_state_event    = st_q.ev;
	assign inrush_state_value    = st_q.ev_val;
	assign irq                   = st_q.irq;

endmodule // inr_detector

/* File: bench/inr_meas_model.sv */
// Measurement stage model: presents three phase magnitudes and a periodic sample strobe.
// Assumes the bench sets target magnitudes; they are taken only at a strobe.
`timescale 1ns/10ps
module inr_meas_model
	import inr_pkg::*;
#(
	parameter int PER = 5
)(
	input  wire logic                  clk,
	input  wire logic                  rstn,
	input  wire logic [2:0][MAG_W-1:0] tgt_f,
	input  wire logic [2:0][MAG_W-1:0] tgt_h,
	output logic      [2:0][MAG_W-1:0] fund,
	output logic      [2:0][MAG_W-1:0] harm,
	output logic                       strobe
);
	logic [7:0] cnt_q;

	// Loads both magnitudes of every phase together and pulses the strobe for one cycle.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= 8'h00;
			strobe <= 1'b0;
			fund <= '0;
			harm <= '0;
		end else begin
			cnt_q <= (cnt_q == 8'(PER - 1)) ? 8'h00 : cnt_q + 8'h01;
			strobe <= (cnt_q == 8'h00);
			if (cnt_q == 8'h00) begin
				fund <= tgt_f;
				harm <= tgt_h;
			end
		end
	end
endmodule // inr_meas_model

/* File: bench/inr_detector_properties.sv */
// Port-level checker of the inrush detector.
// Assumes one clock domain; bound to every detector instance.
`timescale 1ns/10ps
module inr_detector_chk
	import inr_pkg::*;
#(
	parameter int NPH = 3
)(
	input wire logic                      hclk,
	input wire logic                      hresetn,
	input wire logic                      hsel,
	input wire logic [1:0]                htrans,
	input wire logic                      hready,
	input wire logic                      hreadyout,
	input wire logic                      hresp,
	input wire logic [NPH-1:0][MAG_W-1:0] phase_fund,
	input wire logic [NPH-1:0][MAG_W-1:0] phase_harm,
	input wire logic                      sample_strobe,
	input wire logic                      inrush_block_input,
	input wire logic                      phase_a_inrush_flag,
	input wire logic                      phase_b_inrush_flag,
	input wire logic                      phase_c_inrush_flag,
	input wire logic                      any_phase_inrush_flag,
	input wire logic                      inrush_state_event,
	input wire logic                      inrush_state_value
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// Flag relations against their causes.
	chk_any_or: assert property (any_phase_inrush_flag ==
		(phase_a_inrush_flag | phase_b_inrush_flag | phase_c_inrush_flag))
		else $error("general flag differs from OR of phases");
	chk_block_clears: assert property (inrush_block_input |=> !(any_phase_inrush_flag
		| phase_a_inrush_flag | phase_b_inrush_flag | phase_c_inrush_flag))
		else $error("flag high after block");
	chk_rise_strobe: assert property ($rose(any_phase_inrush_flag) |-> $past(sample_strobe))
		else $error("flag rose without strobe");
	chk_harm_zero: assert property (sample_strobe && phase_harm[0] == '0
		|=> !phase_a_inrush_flag) else $error("phase a flag without harmonic");
	chk_fund_zero: assert property (sample_strobe && phase_fund[1] == '0
		|=> !phase_b_inrush_flag) else $error("phase b flag below floor");
	chk_phase_c: assert property (sample_strobe && phase_harm[2] == '0
		|=> !phase_c_inrush_flag) else $error("phase c flag without harmonic");
	chk_event_edge: assert property (inrush_state_event == $changed(any_phase_inrush_flag))
		else $error("event pulse not tied to flag change");
	chk_event_value: assert property (inrush_state_event |->
		inrush_state_value == any_phase_inrush_flag) else $error("event value wrong");
	// Bus slave stalls exactly one cycle and always answers OKAY.
	chk_bus_stall: assert property (hsel && htrans[1] && hready && hreadyout
		|=> !hreadyout ##1 hreadyout) else $error("data phase length wrong");
	chk_resp_okay: assert property (hresp == 1'b0) else $error("response not OKAY");
	cover property ($rose(any_phase_inrush_flag));
	cover property (inrush_state_event && !inrush_state_value);
	cover property (inrush_block_input ##1 !any_phase_inrush_flag);
endmodule // inr_detector_chk

bind inr_detector inr_detector_chk #(.NPH(NPH)) i_inr_detector_chk (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .phase_fund(phase_fund), .phase_harm(phase_harm),
	.sample_strobe(sample_strobe), .inrush_block_input(inrush_block_input),
	.phase_a_inrush_flag(phase_a_inrush_flag), .phase_b_inrush_flag(phase_b_inrush_flag),
	.phase_c_inrush_flag(phase_c_inrush_flag), .any_phase_inrush_flag(any_phase_inrush_flag),
	.inrush_state_event(inrush_state_event), .inrush_state_value(inrush_state_value));

/* File: bench/inr_detector_tb.sv */
// Self-checking bench of the inrush detector, one task per scenario.
// Assumes hready loops back from hreadyout and the model strobes every five cycles.
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
	$display("[ERR] %0t got %h exp %h", $time, g, e); end end
module inr_detector_tb;
	import inr_pkg::*;
	logic                  hclk, hresetn, hsel, hwrite, hreadyout, hresp, strobe, blk;
	logic [31:0]           haddr, hwdata, hrdata, rd;
	logic [1:0]            htrans;
	logic [2:0][MAG_W-1:0] tf, th, fund, harm;
	logic                  fa, fb, fc, fany, ev, evv, irq;
	int                    errors, cmp_count;
	int                    ev_on, ev_off;

	inr_meas_model #(.PER(5)) i_inr_meas_model (.clk(hclk), .rstn(hresetn), .tgt_f(tf),
		.tgt_h(th), .fund(fund), .harm(harm), .strobe(strobe));
	inr_detector i_inr_detector (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .phase_fund(fund),
		.phase_harm(harm), .sample_strobe(strobe), .inrush_block_input(blk),
		.phase_a_inrush_flag(fa), .phase_b_inrush_flag(fb), .phase_c_inrush_flag(fc),
		.any_phase_inrush_flag(fany), .inrush_state_event(ev), .inrush_state_value(evv),
		.irq(irq));

	// Free-running bus clock.
	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	// Counts event pulses by the value that they carry, while each pulse stands.
	always @(negedge hclk) begin
		if (ev === 1'b1 && evv === 1'b1) ev_on++;
		else if (ev === 1'b1) ev_off++;
	end

	task automatic stop_test;
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// Waits for hready, sampled at the level that the next rising edge sees.
	task automatic wt;
		int n;
		n = 0;
		do begin @(negedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50) begin errors++; stop_test(); end
	endtask

	task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {27'h0, a};
		wt();
		@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		wt();
		@(posedge hclk);
		rd = hrdata;
	endtask

	task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask

	// Lets two strobes pass so the flags reflect the newest magnitudes.
	task automatic settle;
		int n;
		repeat (2) begin
			n = 0;
			do begin @(negedge hclk); n++; end while (strobe !== 1'b1 && n < 40);
			if (n >= 40) begin errors++; stop_test(); end
		end
		@(negedge hclk);
	endtask

	task automatic t_defaults;
		rdc(OFS_CTRL, 32'h0);
		rdc(OFS_RATIO, 32'h0000000F);
		rdc(OFS_MINLVL, 32'h0000001E);
		rdc(OFS_RATED, 32'h00001000);
		rdc(OFS_EVMASK, 32'h0);
		@(posedge hclk);
		tf <= {3{16'h1000}};
		th <= {3{16'h0800}};
		settle();
		`CHK({fc, fb, fa, fany}, 4'h0)
	endtask

	task automatic t_clamp;
		bus(1'b1, OFS_RATIO, 32'h2);
		rdc(OFS_RATIO, 32'h00000005);
		bus(1'b1, OFS_RATIO, 32'h3F);
		rdc(OFS_RATIO, 32'h00000032);
		bus(1'b1, OFS_MINLVL, 32'h10);
		rdc(OFS_MINLVL, 32'h00000014);
		bus(1'b1, OFS_MINLVL, 32'h7F);
		rdc(OFS_MINLVL, 32'h00000064);
		bus(1'b1, OFS_RATIO, 32'h0F);
		bus(1'b1, OFS_MINLVL, 32'h1E);
	endtask

	// Each pass: one phase just over the ratio, one at the floor, one at the ratio.
	task automatic t_phases;
		logic [2:0][MAG_W-1:0] f, h;
		bus(1'b1, OFS_RATED, 32'h3E8);
		bus(1'b1, OFS_CTRL, 32'h1);
		for (int i = 0; i < 3; i++) begin
			f = {3{16'h03E8}};
			h = {3{16'h0096}};
			h[i] = 16'h0097;
			f[(i + 1) % 3] = 16'h012C;
			h[(i + 1) % 3] = 16'h01F4;
			@(posedge hclk);
			tf <= f;
			th <= h;
			settle();
			`CHK({fc, fb, fa}, 3'(1 << i))
			`CHK(fany, 1'b1)
			`CHK(irq, 1'b0)
		end
		rdc(OFS_FLAGS, 32'h0000002C);
		rdc(OFS_EVSTAT, 32'h00000001);
	endtask

	// Zero harmonic on one phase and zero fundamental on another, then zero harmonic on c.
	task automatic t_zero;
		logic [2:0][MAG_W-1:0] f, h;
		f = {3{16'h03E8}};
		h = {3{16'h01F4}};
		h[0] = 16'h0000;
		f[1] = 16'h0000;
		@(posedge hclk);
		tf <= f;
		th <= h;
		settle();
		`CHK({fc, fb, fa}, 3'b100)
		h = {3{16'h01F4}};
		h[2] = 16'h0000;
		@(posedge hclk);
		tf <= {3{16'h03E8}};
		th <= h;
		settle();
		`CHK({fc, fb, fa}, 3'b011)
		`CHK(fany, 1'b1)
	endtask

	task automatic t_block;
		bus(1'b1, OFS_EVMASK, 32'h3);
		@(posedge hclk);
		blk <= 1'b1;
		settle();
		`CHK({fc, fb, fa, fany}, 4'h0)
		`CHK(irq, 1'b1)
		rdc(OFS_FLAGS, 32'h00000030);
		rdc(OFS_EVSTAT, 32'h00000002);
		repeat (2) @(negedge hclk);
		`CHK(irq, 1'b0)
		@(posedge hclk);
		blk <= 1'b0;
		settle();
		`CHK(fany, 1'b1)
		bus(1'b1, OFS_CTRL, 32'h0);
		settle();
		`CHK(fany, 1'b0)
		rdc(OFS_EVCNT, 32'h00000004);
		`CHK(ev_on, 2)
		`CHK(ev_off, 2)
	endtask

	// Reset, then the scenarios in turn.
	initial begin
		{hsel, hwrite, blk, hresetn} = 4'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'b00;
		tf = '0;
		th = '0;
		errors = 0;
		cmp_count = 0;
		ev_on = 0;
		ev_off = 0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		t_defaults();
		t_clamp();
		t_phases();
		t_zero();
		t_block();
		stop_test();
	end
endmodule // inr_detector_tb
